/* core/timed_poll_scheduler.sv */
// Purpose: timed read/write message originator with single-entry and table scan modes
// Assumes: reply port on the same clock; one request in flight at a time
// Notes: registers over APB, always ready; unmapped access answers pslverr
`timescale 1ns/1ps
`default_nettype none
module timed_poll_scheduler #(
  parameter int TICK_CYCLES = poll_pkg::TICK_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             req_valid,
  input  wire logic        req_ready,
  output logic             req_write,
  output logic      [11:0] req_local,
  output logic      [15:0] req_remote,
  output logic      [7:0]  req_count,
  output logic      [7:0]  req_route,
  input  wire logic        rsp_valid,
  input  wire logic        rsp_ok,
  output logic             bus_master,
  output logic             slave_refuse
);

  typedef struct packed {
    logic [15:0]                          interval;
    logic [1:0]                           port_kind;
    logic                                 peer_bcast;
    logic                                 fieldbus;
    logic                                 status_en;
    logic [7:0]                           rd_count;
    logic [11:0]                          rd_to;
    logic [15:0]                          rd_from;
    logic [7:0]                           wr_count;
    logic [11:0]                          wr_from;
    logic [15:0]                          wr_to;
    logic [7:0]                           route;
    logic [poll_pkg::ENTRIES-1:0][63:0]   tbl;
    logic [poll_pkg::ENTRIES-1:0]         status;
    poll_pkg::seq_e                       seq;
    logic [17:0]                          tick_cnt;
    logic [15:0]                          timer;
    logic                                 pending;
    logic                                 write_due;
    logic                                 cur_scan;
    logic [poll_pkg::IDX_W-1:0]           cur_idx;
    logic                                 cur_write;
    logic [11:0]                          cur_local;
    logic [15:0]                          cur_remote;
    logic [7:0]                           cur_count;
    logic [7:0]                           cur_route;
    logic [31:0]                          rdata;
    logic                                 err;
  } state_s;

  state_s q;
  state_s d;

  // an entry is usable only when every field is non-zero and in range
  function automatic logic entry_ok(input logic [63:0] e);
    logic [11:0] loc;
    logic [13:0] rem;
    logic [7:0]  cnt;
    logic [7:0]  rte;
    loc = e[11:0];
    rem = e[29:16];
    cnt = e[39:32];
    rte = e[55:48];
    entry_ok = (loc != 12'h000) && (loc <= poll_pkg::MAX_LOCAL)
            && (rem != 14'h0000) && (rem <= poll_pkg::MAX_REMOTE)
            && (cnt != 8'h00) && (cnt <= poll_pkg::MAX_COUNT)
            && (rte != 8'h00);
  endfunction

  // count field check shared by read and write of single mode
  function automatic logic count_ok(input logic [7:0] c);
    count_ok = (c != 8'h00) && (c <= poll_pkg::MAX_COUNT);
  endfunction

  // first valid entry after start, ascending with wrap
  function automatic logic [poll_pkg::IDX_W-1:0] next_entry(input logic [poll_pkg::ENTRIES-1:0] v,
                                                            input logic [poll_pkg::IDX_W-1:0] start);
    int i;
    int k;
    logic found;
    next_entry = start;
    found = 1'b0;
    for (k = 1; k <= poll_pkg::ENTRIES; k++) begin
      i = (int'(start) + k) % poll_pkg::ENTRIES;
      if (!found && v[i]) begin
        next_entry = poll_pkg::IDX_W'(i);
        found = 1'b1;
      end
    end
  endfunction

  // per-entry validity
  logic [poll_pkg::ENTRIES-1:0] valid;
  genvar g;
  generate
    for (g = 0; g < poll_pkg::ENTRIES; g++) begin : g_valid
      assign valid[g] = entry_ok(q.tbl[g]);
    end
  endgenerate

  logic any_valid;
  logic scan_active;
  logic single_port;
  logic rd_en;
  logic wr_en;
  logic single_active;
  logic pick_write;
  logic [poll_pkg::IDX_W-1:0] pick_idx;
  logic tick;
  logic expire;
  logic retry_done;
  logic acc;
  logic wr_acc;
  logic in_table;
  logic [poll_pkg::IDX_W-1:0] widx;
  logic [11:0] toff;

  // mode selection
  assign any_valid     = |valid;
  assign scan_active   = (q.interval != 16'h0000) && any_valid
                      && (q.port_kind == poll_pkg::PORT_SERIAL);
  assign single_port   = (q.port_kind == poll_pkg::PORT_SERIAL)
                      || ((q.port_kind == poll_pkg::PORT_NETWORK) && !q.peer_bcast);
  assign rd_en         = count_ok(q.rd_count)
                      && (q.rd_to != 12'h000) && (q.rd_to <= poll_pkg::MAX_LOCAL);
  assign wr_en         = count_ok(q.wr_count);
  assign single_active = (q.interval != 16'h0000) && !any_valid && single_port
                      && (rd_en || wr_en);
  assign pick_write    = wr_en && (!rd_en || q.write_due);
  assign pick_idx      = next_entry(valid, q.cur_idx);

  // timing strobes
  assign tick       = (q.tick_cnt == 18'(TICK_CYCLES - 1));
  assign expire     = tick && ((q.timer + 16'h0001) >= q.interval);
  assign retry_done = tick && ((q.timer + 16'h0001) >= poll_pkg::RETRY_TICKS);

  // apb decode
  assign acc      = psel && penable;
  assign wr_acc   = acc && pwrite;
  assign toff     = paddr - poll_pkg::OFS_TABLE;
  assign in_table = (paddr >= poll_pkg::OFS_TABLE) && (toff < poll_pkg::TABLE_BYTES);
  assign widx     = toff[8:3];

  // next state
  always_comb begin
    d = q;
    d.tick_cnt = tick ? 18'h00000 : q.tick_cnt + 18'h00001;
    d.rdata = 32'h0000_0000;
    d.err = 1'b0;
    // reads decode from setup so prdata stands in the access phase; writes land at the access edge
    if (psel && (paddr[1:0] == 2'h0)) begin
      if (in_table) begin
        d.rdata = toff[2] ? q.tbl[widx][63:32] : q.tbl[widx][31:0];
        if (wr_acc && toff[2]) begin
          d.tbl[widx][63:32] = pwdata;
        end else if (wr_acc) begin
          d.tbl[widx][31:0] = pwdata;
        end
      end else begin
        case (paddr)
          poll_pkg::OFS_CTRL: begin
            d.rdata = {11'h000, q.status_en, q.fieldbus, q.peer_bcast, q.port_kind, q.interval};
            if (wr_acc) begin
              d.interval   = pwdata[15:0];
              d.port_kind  = pwdata[17:16];
              d.peer_bcast = pwdata[18];
              d.fieldbus   = pwdata[19];
              d.status_en  = pwdata[20];
            end
          end
          poll_pkg::OFS_RD_CFG: begin
            d.rdata = {4'h0, q.rd_to, 8'h00, q.rd_count};
            if (wr_acc) begin
              d.rd_count = pwdata[7:0];
              d.rd_to    = pwdata[27:16];
            end
          end
          poll_pkg::OFS_RD_FROM: begin
            d.rdata = {16'h0000, q.rd_from};
            if (wr_acc) begin
              d.rd_from = pwdata[15:0];
            end
          end
          poll_pkg::OFS_WR_CFG: begin
            d.rdata = {4'h0, q.wr_from, 8'h00, q.wr_count};
            if (wr_acc) begin
              d.wr_count = pwdata[7:0];
              d.wr_from  = pwdata[27:16];
            end
          end
          poll_pkg::OFS_WR_TO: begin
            d.rdata = {16'h0000, q.wr_to};
            if (wr_acc) begin
              d.wr_to = pwdata[15:0];
            end
          end
          poll_pkg::OFS_ROUTE: begin
            d.rdata = {24'h000000, q.route};
            if (wr_acc) begin
              d.route = pwdata[7:0];
            end
          end
          poll_pkg::OFS_STATE: begin
            d.rdata = {10'h000, q.cur_idx, 10'h000, single_active, scan_active, q.pending,
                       q.cur_write, 2'(q.seq)};
          end
          poll_pkg::OFS_STAT0: d.rdata = {16'h0000, q.status[15:0]};
          poll_pkg::OFS_STAT1: d.rdata = {16'h0000, q.status[31:16]};
          poll_pkg::OFS_STAT2: d.rdata = {16'h0000, q.status[47:32]};
          default: d.err = 1'b1;
        endcase
      end
    end else if (acc) begin
      d.err = 1'b1;
    end

    // status bits: disabled entries clear, reply result sets or clears
    d.status = q.status & valid & {poll_pkg::ENTRIES{q.status_en}};
    if (rsp_valid && q.pending && q.cur_scan && q.status_en) begin
      d.status[q.cur_idx] = rsp_ok && valid[q.cur_idx];
    end
    if (rsp_valid) begin
      d.pending = 1'b0;
    end

    // sequencer
    case (q.seq)
      poll_pkg::ST_IDLE: begin
        d.timer = 16'h0000;
        if (scan_active || single_active) begin
          d.seq = poll_pkg::ST_ISSUE;
          d.cur_scan = scan_active;
          if (scan_active) begin
            d.cur_idx    = pick_idx;
            d.cur_write  = q.tbl[pick_idx][63];
            d.cur_local  = q.tbl[pick_idx][11:0];
            d.cur_remote = {2'h0, q.tbl[pick_idx][29:16]};
            d.cur_count  = q.tbl[pick_idx][39:32];
            d.cur_route  = q.tbl[pick_idx][55:48];
          end else begin
            d.cur_write  = pick_write;
            d.write_due  = !pick_write;                                    // read goes first
            d.cur_local  = pick_write ? q.wr_from : q.rd_to;
            d.cur_remote = pick_write ? q.wr_to : q.rd_from;
            d.cur_count  = pick_write ? q.wr_count : q.rd_count;
            d.cur_route  = q.route;
          end
        end
      end
      poll_pkg::ST_ISSUE: begin
        if (req_ready) begin
          d.seq = poll_pkg::ST_WAIT;
          d.pending = 1'b1;
          d.timer = 16'h0000;
          d.tick_cnt = 18'h00000;
        end
      end
      poll_pkg::ST_WAIT: begin
        if (q.interval == 16'h0000) begin
          d.seq = poll_pkg::ST_IDLE;
        end else if (expire) begin
          d.timer = 16'h0000;
          d.seq = (q.pending && !rsp_valid) ? poll_pkg::ST_DELAY : poll_pkg::ST_IDLE;
        end else if (tick) begin
          d.timer = q.timer + 16'h0001;
        end
      end
      poll_pkg::ST_DELAY: begin
        if (retry_done) begin
          d.seq = poll_pkg::ST_IDLE;
          d.pending = 1'b0;
        end else if (tick) begin
          d.timer = q.timer + 16'h0001;
        end
      end
      default: d.seq = poll_pkg::ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // outputs
  assign prdata       = q.rdata;
  assign pslverr      = acc && d.err;
  assign pready       = 1'b1;
  assign req_valid    = (q.seq == poll_pkg::ST_ISSUE);
  assign req_write    = q.cur_write;
  assign req_local    = q.cur_local;
  assign req_remote   = q.cur_remote;
  assign req_count    = q.cur_count;
  assign req_route    = q.cur_route;
  assign bus_master   = q.fieldbus && (scan_active || single_active);
  assign slave_refuse = q.fieldbus && scan_active;

endmodule // timed_poll_scheduler
`default_nettype wire

/* inc/poll_pkg.sv */
// Purpose: constants shared by the timed poll scheduler
// Assumes: 20 MHz clock, APB register access, 32-bit data
// Notes: Notes on behaviour list below
// Notes on behaviour
// - messages spaced by interval in 10 ms
// - read and write alternate when both enabled
// - late reply adds two second delay
// - zero interval stops single-entry transfers
// - zero interval stops whole scan table
// - only non-empty entries consume interval time
// - single mode: one read, one write, one route
// - read count at most 128, zero disables
// - single read destination only 1 to 2048
// - write count 0 to 128, zero disables
// - network port only without peer broadcast
// - 48-entry table, serial ports only
// - local pointer 1 to 2048, zero disables
// - remote pointer 1 to 8192, zero disables
// - count 1 to 128, zero disables
// - read fetches remote to local, write opposite
// - valid entry needs all fields; disables single
// - table on field-bus port forces master only
// - single mode on field-bus port makes master
// - per-entry status bits in three words
package poll_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_RD_CFG   = 12'h004;
  localparam logic [11:0] OFS_RD_FROM  = 12'h008;
  localparam logic [11:0] OFS_WR_CFG   = 12'h00C;
  localparam logic [11:0] OFS_WR_TO    = 12'h010;
  localparam logic [11:0] OFS_ROUTE    = 12'h014;
  localparam logic [11:0] OFS_STATE    = 12'h018;
  localparam logic [11:0] OFS_STAT0    = 12'h020;
  localparam logic [11:0] OFS_STAT1    = 12'h024;
  localparam logic [11:0] OFS_STAT2    = 12'h028;
  localparam logic [11:0] OFS_TABLE    = 12'h100;
  localparam logic [11:0] TABLE_BYTES  = 12'h180;
  // table geometry
  localparam int          ENTRIES      = 48;
  localparam int          IDX_W        = 6;
  // value limits
  localparam logic [7:0]  MAX_COUNT    = 8'h80;
  localparam logic [11:0] MAX_LOCAL    = 12'h800;
  localparam logic [13:0] MAX_REMOTE   = 14'h2000;
  // port kinds
  localparam logic [1:0]  PORT_SERIAL  = 2'h0;
  localparam logic [1:0]  PORT_NETWORK = 2'h1;
  localparam logic [1:0]  PORT_TOKEN   = 2'h2;
  // timing
  localparam int          CLOCK_HZ     = 20000000;
  localparam int          TICK_MS      = 10;
  localparam int          TICK_CYCLES  = CLOCK_HZ / 1000 * TICK_MS;
  localparam int          RETRY_MS     = 2000;
  localparam logic [15:0] RETRY_TICKS  = 16'(RETRY_MS / TICK_MS);
  // sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_DELAY} seq_e;
endpackage

/* test/poll_asserts.sv */
// Purpose: timing and range checks on the poll request port of the scheduler
// Assumes: interval and port kind are shadowed from CTRL writes seen on the bus ports
// Notes: the gap counter saturates after reset or a CTRL write, so no spacing is claimed then
`timescale 1ns/1ps
`default_nettype none
module poll_asserts #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic        req_write,
  input wire logic [11:0] req_local,
  input wire logic [15:0] req_remote,
  input wire logic [7:0]  req_count,
  input wire logic [7:0]  req_route,
  input wire logic        rsp_valid
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic [31:0] ctrl;
  logic [19:0] gap;
  logic [1:0]  age;
  logic        seen;
  wire         ctrl_wr = psel && penable && pwrite && paddr == poll_pkg::OFS_CTRL;
  wire         take    = req_valid && req_ready;
  wire  [15:0] ivl     = ctrl[15:0];
  wire         quiet   = ivl == 16'h0 || ctrl[17:16] == poll_pkg::PORT_TOKEN ||
                         (ctrl[17:16] == poll_pkg::PORT_NETWORK && ctrl[18]);
  // shadow of the control word, cycles since acceptance, reply seen since then
  always_ff @(posedge clock) begin
    if (rst || ctrl_wr) begin
      ctrl <= rst ? 32'h0 : pwdata;
      gap  <= 20'hFFFFF;
      seen <= 1'b1;
      age  <= 2'h0;
    end else begin
      if (age != 2'h3) age <= age + 2'h1;
      if (take) gap <= 20'h1;
      else if (gap != 20'hFFFFF) gap <= gap + 20'h1;
      if (take) seen <= 1'b0;
      else if (rsp_valid) seen <= 1'b1;
    end
  end
  sequence s_offered;
    req_valid && !req_ready;
  endsequence
  sequence s_held;
    req_valid && $stable({req_write, req_local, req_remote, req_count, req_route});
  endsequence
  a_req_held: assert property (s_offered |=> s_held)
    else $error("request changed before acceptance");
  a_req_drop: assert property (take |=> !req_valid)
    else $error("request still offered after acceptance");
  a_count_range: assert property (req_valid |-> req_count != 8'h0 && req_count <= poll_pkg::MAX_COUNT)
    else $error("request count out of range");
  a_local_range: assert property (req_valid |-> req_local != 12'h0 && req_local <= poll_pkg::MAX_LOCAL)
    else $error("mailbox pointer out of range");
  a_msg_gap: assert property ($rose(req_valid) |-> gap >= ivl * TICK_CYCLES)
    else $error("request issued before the interval ran out");
  a_retry_gap: assert property ($rose(req_valid) && !seen |-> gap >= (ivl + 200) * TICK_CYCLES)
    else $error("missing reply did not add the long delay");
  a_port_quiet: assert property (age == 2'h3 && quiet |-> !$rose(req_valid))
    else $error("request issued while transfers are off");
  a_bus_refuse: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
endmodule // poll_asserts
bind timed_poll_scheduler poll_asserts #(.TICK_CYCLES(TICK_CYCLES)) poll_asserts_inst (
  .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pslverr(pslverr), .req_valid(req_valid), .req_ready(req_ready),
  .req_write(req_write), .req_local(req_local), .req_remote(req_remote), .req_count(req_count),
  .req_route(req_route), .rsp_valid(rsp_valid));
`default_nettype wire

/* test/port_model.sv */
// Purpose: remote controller seen through the port, one request at a time
// Assumes: lags and answer kind set by the bench between scenarios
// Notes: a silent answer leaves the request outstanding
`timescale 1ns/1ps
`default_nettype none
module port_model (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       req_valid,
  input  wire logic       ans_en,
  input  wire logic       ans_ok,
  input  wire logic [3:0] rdy_lag,
  input  wire logic [3:0] rsp_lag,
  output var  logic       req_ready,
  output var  logic       rsp_valid,
  output var  logic       rsp_ok
);
  initial begin
    req_ready = 1'b0;
    rsp_valid = 1'b0;
    rsp_ok    = 1'b0;
  end
  // take a request after a lag, then answer it or stay silent
  always begin
    @(posedge clock);
    if (!rst && req_valid) begin
      repeat (rdy_lag) @(posedge clock);
      req_ready <= 1'b1;
      @(posedge clock);
      req_ready <= 1'b0;
      if (ans_en) begin
        repeat (rsp_lag) @(posedge clock);
        rsp_valid <= 1'b1;
        rsp_ok    <= ans_ok;
        @(posedge clock);
        rsp_valid <= 1'b0;
        rsp_ok    <= ~ans_ok; // released qualifier shows the opposite level
      end
    end
  end
endmodule // port_model
`default_nettype wire

/* test/tb_top.sv */
// Purpose: scenario bench for the timed poll scheduler
// Assumes: shortened tick of 20 cycles, partner answers per scenario
// Notes: accepted requests are logged with their cycle for spacing checks
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin num_errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  localparam int TICK = 20;
  logic clock, rst, psel, penable, pwrite, pready, pslverr, req_valid, req_ready, req_write;
  logic rsp_valid, rsp_ok, bus_master, slave_refuse, ans_en, ans_ok;
  logic [11:0] paddr, req_local;
  logic [31:0] pwdata, prdata, x;
  logic [15:0] req_remote;
  logic [7:0]  req_count, req_route;
  logic [3:0]  rdy_lag, rsp_lag;
  logic [44:0] reqs[$], e[4];
  int          at[$], num_errors, total_checks, cycles;
  timed_poll_scheduler #(.TICK_CYCLES(TICK)) timed_poll_scheduler_inst (.clock(clock), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_local(req_local), .req_remote(req_remote), .req_count(req_count), .req_route(req_route),
    .rsp_valid(rsp_valid), .rsp_ok(rsp_ok), .bus_master(bus_master), .slave_refuse(slave_refuse));
  port_model port_model_inst (.clock(clock), .rst(rst), .req_valid(req_valid), .ans_en(ans_en),
    .ans_ok(ans_ok), .rdy_lag(rdy_lag), .rsp_lag(rsp_lag), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_ok(rsp_ok));
  always #25 clock = ~clock;
  // log accepted requests and cut a hang short
  always @(posedge clock) begin
    cycles++;
    if (req_valid === 1'b1 && req_ready === 1'b1) begin
      reqs.push_back({req_write, req_local, req_remote, req_count, req_route});
      at.push_back(cycles);
    end
    if (cycles >= 60000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic test_done();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic er);
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    er = pslverr;
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic er;
    apb(1'b1, a, d, x, er);
  endtask
  task automatic do_reset();
    @(posedge clock);
    rst <= 1'b1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    reqs.delete();
    at.delete();
  endtask
  task automatic wait_n(input int n);
    while (reqs.size() < n) @(posedge clock);
  endtask
  // single-entry set-up; interval 5 ticks leaves ample room for the reply
  task automatic cfg(input logic [7:0] rc, input logic [11:0] rd, input logic [7:0] wc, input logic [31:0] c);
    wr(poll_pkg::OFS_RD_CFG, {4'h0, rd, 8'h0, rc});
    wr(poll_pkg::OFS_RD_FROM, 32'h1234);
    wr(poll_pkg::OFS_WR_CFG, {4'h0, 12'h001, 8'h0, wc});
    wr(poll_pkg::OFS_WR_TO, 32'h4321);
    wr(poll_pkg::OFS_ROUTE, 32'h7D);
    wr(poll_pkg::OFS_CTRL, c);
  endtask
  task automatic ent(input int i, input logic [11:0] l, input logic [13:0] r, input logic d, input logic [7:0] rt, c);
    wr(12'(poll_pkg::OFS_TABLE + 8 * i), {2'h0, r, 4'h0, l});
    wr(12'(poll_pkg::OFS_TABLE + 8 * i + 4), {d, 7'h0, rt, 8'h0, c});
  endtask
  // reset values, read-only words, refused addresses
  task automatic test_regs();
    logic er;
    apb(1'b1, poll_pkg::OFS_STAT0, 32'hFFFF, x, er);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(poll_pkg::OFS_STATE + (i == 0 ? 0 : 4 * i + 4)), 32'h0, x, er);
      `CHK("status word", 32'h0, x)
    end
    `CHK("master level", 2'h0, {bus_master, slave_refuse})
    apb(1'b0, 12'h002, 32'h0, x, er);
    `CHK("misaligned error", 1'b1, er)
    apb(1'b1, 12'h0FC, 32'h1, x, er);
    `CHK("unmapped error", 1'b1, er)
  endtask
  // read and write alternate with boundary fields, field-bus master
  task automatic test_single();
    logic er;
    do_reset();
    rdy_lag = 4'h2;
    cfg(8'h80, 12'h800, 8'h01, 32'h0008_0005);
    apb(1'b0, poll_pkg::OFS_RD_CFG, 32'h0, x, er);
    `CHK("read config", 32'h0800_0080, x)
    wait_n(3);
    e[0] = {1'b0, 12'h800, 16'h1234, 8'h80, 8'h7D};
    e[1] = {1'b1, 12'h001, 16'h4321, 8'h01, 8'h7D};
    for (int i = 0; i < 3; i++) `CHK("single request", e[i % 2], reqs[i])
    `CHK("single spacing", 1'b1, at[1] - at[0] >= 5 * TICK && at[1] - at[0] <= 5 * TICK + 12)
    `CHK("master level", 2'h2, {bus_master, slave_refuse})
  endtask
  // disabled read or write leaves only the other kind
  task automatic test_disable();
    logic [7:0] rc[5] = '{8'h00, 8'h81, 8'h01, 8'h01, 8'h01};
    logic [11:0] rd[5] = '{12'h800, 12'h800, 12'h000, 12'h801, 12'h001};
    for (int i = 0; i < 5; i++) begin
      do_reset();
      cfg(rc[i], rd[i], i == 4 ? 8'h00 : 8'h01, 32'h5);
      wait_n(2);
      `CHK("kind", i == 4 ? 2'h0 : 2'h3, {reqs[0][44], reqs[1][44]})
    end
  endtask
  // zero interval, token bus and peer broadcast stay silent
  task automatic test_quiet();
    logic [31:0] c[4] = '{32'h0, 32'h0002_0005, 32'h0005_0005, 32'h0001_0005};
    for (int i = 0; i < 4; i++) begin
      do_reset();
      cfg(8'h01, 12'h001, 8'h01, c[i]);
      repeat (300) @(posedge clock);
      `CHK("any request", i == 3, reqs.size() != 0)
    end
  endtask
  // silent partner adds the two second delay
  task automatic test_retry();
    do_reset();
    ans_en = 1'b0;
    cfg(8'h04, 12'h010, 8'h00, 32'h5);
    wait_n(3);
    `CHK("retry spacing", 1'b1, at[2] - at[1] >= 205 * TICK && at[2] - at[1] <= 205 * TICK + 30)
    ans_en = 1'b1;
  endtask
  // table order, skipping, status bits, master only, zero interval
  task automatic test_scan();
    logic er;
    do_reset();
    rdy_lag = 4'h0;
    cfg(8'h01, 12'h001, 8'h01, 32'h0);
    ent(0, 12'h800, 14'h2000, 1'b0, 8'h11, 8'h80);
    ent(1, 12'h000, 14'h0005, 1'b0, 8'h11, 8'h01);
    ent(2, 12'h001, 14'h0001, 1'b1, 8'h22, 8'h01);
    ent(3, 12'h001, 14'h2001, 1'b0, 8'h11, 8'h01);
    ent(4, 12'h001, 14'h0001, 1'b0, 8'h11, 8'h81);
    ent(5, 12'h001, 14'h0001, 1'b0, 8'h00, 8'h01);
    ent(47, 12'h7FF, 14'h1FFF, 1'b0, 8'h33, 8'h02);
    wr(poll_pkg::OFS_CTRL, 32'h0018_0005);
    e = '{{1'b1, 12'h001, 16'h0001, 8'h01, 8'h22}, {1'b0, 12'h7FF, 16'h1FFF, 8'h02, 8'h33},
          {1'b0, 12'h800, 16'h2000, 8'h80, 8'h11}, {1'b1, 12'h001, 16'h0001, 8'h01, 8'h22}};
    wait_n(4);
    for (int i = 0; i < 4; i++) `CHK("scan request", e[i], reqs[i])
    `CHK("skip spacing", 1'b1, at[1] - at[0] <= 5 * TICK + 60)
    `CHK("master level", 2'h3, {bus_master, slave_refuse})
    wait_n(6);
    repeat (20) @(posedge clock);
    wr(poll_pkg::OFS_STAT1, 32'h0);
    apb(1'b0, poll_pkg::OFS_STAT0, 32'h0, x, er);
    `CHK("status low", 32'h5, x)
    apb(1'b0, poll_pkg::OFS_STAT2, 32'h0, x, er);
    `CHK("status high", 32'h8000, x)
    ans_ok = 1'b0;
    wait_n(9);
    repeat (20) @(posedge clock);
    apb(1'b0, poll_pkg::OFS_STAT0, 32'h0, x, er);
    `CHK("status cleared", 32'h0, x)
    ans_en = 1'b1;
    wr(poll_pkg::OFS_CTRL, 32'h0018_0000);
    repeat (10) @(posedge clock);
    reqs.delete();
    repeat (300) @(posedge clock);
    `CHK("table off", 0, reqs.size())
  endtask
  initial begin
    clock = 1'b0; rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
    ans_en = 1'b1; ans_ok = 1'b1; rdy_lag = 4'h1; rsp_lag = 4'h1; num_errors = 0; total_checks = 0; cycles = 0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    test_regs();
    test_single();
    test_disable();
    test_quiet();
    test_retry();
    test_scan();
    test_done();
  end
endmodule // tb_top
`default_nettype wire
